//--- core/pmc_pkg.sv
// Package of constants and types for the power mode controller
`default_nettype none
package pmc_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] PMC_PWR_CTRL_ADDR = 8'h87;   // Power control register
  localparam logic [7:0] PMC_CLK_PWR_ADDR  = 8'hB6;   // Clock/power control register
  localparam logic [7:0] PMC_PWR_CTRL_RST  = 8'h00;   // Power control reset value
  localparam logic [2:0] PMC_CLK_PWR_RST   = 3'h0;    // Power-down code reset value
  localparam int PMC_IDLE_BIT   = 0;                  // Idle select
  localparam int PMC_STOP_BIT   = 1;                  // Stop select
  localparam int PMC_FLAG_LO    = 2;                  // Soft flag low
  localparam int PMC_FLAG_HI    = 3;                  // Soft flag high
  localparam int PMC_BAUD_BIT   = 7;                  // Baud doubler
  localparam logic [7:0] PMC_PWR_WMASK = 8'h8F;       // Writable bits of power control
  // ****************************************
  // Power-down codes
  // ****************************************
  localparam logic [2:0] PMC_PD_NORMAL = 3'h0;        // Normal operation
  localparam logic [2:0] PMC_PD_LIGHT  = 3'h1;        // Light, slow clock on crystal
  localparam logic [2:0] PMC_PD_MOD    = 3'h2;        // Moderate, slow clock on crystal
  localparam logic [2:0] PMC_PD_STBY   = 3'h3;        // Standby, slow clock on low power osc
  localparam int PMC_PD_DEEP_BIT = 2;                 // Set: crystal stopped too
  // ****************************************
  // Timing
  // ****************************************
  localparam int PMC_CLK_HZ       = 40_000_000;       // System clock rate
  localparam int PMC_XO_START_US  = 3000;             // Crystal start-up, 3 ms max
  localparam int PMC_XO_START_CYC = PMC_XO_START_US * (PMC_CLK_HZ / 1_000_000);
  localparam int PMC_INIT_CYC     = 2500;             // Initialisation cycles
  // Controller states
  typedef enum logic [2:0] {
    PMC_ST_XO_WAIT = 3'b000,
    PMC_ST_INIT    = 3'b001,
    PMC_ST_RUN     = 3'b010,
    PMC_ST_IDLE    = 3'b011,
    PMC_ST_STOP    = 3'b100,
    PMC_ST_PDOWN   = 3'b101,
    PMC_ST_WAKE    = 3'b110
  } pmc_state_t;
endpackage
`default_nettype wire

//--- core/pmc_cnt_if.sv
// Interface between the controller and its cycle counter
`default_nettype none
interface pmc_cnt_if;
  logic        load;    // Load a new count
  logic [17:0] value;   // Count to load
  logic        done;    // Count reached zero
  modport ctrl (output load, output value, input done);
  modport cnt  (input load, input value, output done);
endinterface
`default_nettype wire

//--- core/pmc_cycle_cnt.sv
// Down counter that times start-up phases
`default_nettype none
module pmc_cycle_cnt
  import pmc_pkg::*;
(
  input  wire logic sys_clk_i,    // System clock
  input  wire logic reset_n_i,    // Async reset, active low
  pmc_cnt_if.cnt    cnt           // Load and done
);
  logic [17:0] count_reg;         // Remaining cycles
  // Load or count down to zero
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_reg <= 18'h0_0000;
    end else if (cnt.load) begin
      count_reg <= cnt.value;
    end else if (count_reg != 18'h0_0000) begin
      count_reg <= count_reg - 18'h0_0001;
    end
  end
  // Done depends on the count alone, so the load logic may read it freely
  assign cnt.done = (count_reg == 18'h0_0000);
endmodule
`default_nettype wire

//--- core/pmc_power_mode_ctrl.sv
// Power mode controller: idle, stop, power-down and start-up sequencing
//
// Functional notes
// [R1] Idle entered after setting instruction completes
// [R2] Idle suspends CPU, clock keeps running
// [R3] Enabled interrupt clears idle bit, resumes
// [R4] Watchdog reset ends any mode, restarts
// [R5] Stop bit enters stop; watchdog only exit
// [R6] Software should prefer power-down over stop
// [R7] Non-zero power-down code write enters power-down
// [R8] Power-down suspends CPU, shuts clocks, regulators
// [R9] Code selects slow clock source and crystal
// [R10] Only pin, RTC or watchdog wake
// [R11] Wakeup clears code, then interrupt runs
// [R12] Pin debounce keeps device in power-down
// [R13] Read returns slow clock level bit 0
// [R14] Software checks indirect busy before writing
// [R15] Low power osc wake may lose interrupt
// [R16] Start-up: crystal wait then init cycles
// [R17] Bits 3 and 2 plain soft flags
// [R18] Bit 7 doubles serial baud rate
// [R19] Bits 6 to 4 read zero
`default_nettype none
module pmc_power_mode_ctrl
  import pmc_pkg::*;
#(
  parameter int XO_START_CYC = PMC_XO_START_CYC,   // Crystal start-up cycles
  parameter int INIT_CYC     = PMC_INIT_CYC        // Initialisation cycles
)(
  input  wire logic       sys_clk_i,         // System clock, 40 MHz
  input  wire logic       reset_n_i,         // Power-on reset, active low
  input  wire logic       wdog_reset_i,      // Watchdog reset request, pulse
  input  wire logic       sfr_wr_i,          // Register write strobe
  input  wire logic       sfr_rd_i,          // Register read strobe
  input  wire logic [7:0] sfr_addr_i,        // Register address
  input  wire logic [7:0] sfr_wdata_i,       // Write data
  output logic      [7:0] sfr_rdata_o,       // Read data, registered
  input  wire logic       instr_done_i,      // Current instruction completes
  input  wire logic       irq_pending_i,     // Any enabled interrupt pending
  input  wire logic       pin_wake_i,        // Port pin event after debounce
  input  wire logic       rtc_wake_i,        // RTC wakeup event
  input  wire logic       slow_clock_level_i, // Slow clock level
  input  wire logic       wake_ready_i,      // Power and clocks restored after wake
  output logic            cpu_hold_o,        // CPU processing suspended
  output logic            cpu_reset_o,       // CPU and registers held in reset
  output logic            baud_double_bit_o, // Serial baud doubler
  output logic            crystal_clock_on_o,         // Crystal oscillator enable
  output logic            slow_clock_source_o, // 1: low power osc, 0: crystal
  output logic            pd_request_o,      // Clock and regulator shutdown
  output logic      [2:0] pd_level_o         // Active power-down code
);
  // ****************************************
  // Registers
  // ****************************************
  pmc_state_t  state_reg;              // Controller state
  logic [7:0]  power_control_reg;      // Power control contents
  logic [2:0]  clock_power_ctrl_reg;   // Power-down code
  logic [2:0]  pd_active_reg;          // Code taken on entry
  logic        idle_pend_reg;          // Idle requested, wait instruction end
  logic        stop_pend_reg;          // Stop requested
  logic        pd_pend_reg;            // Power-down requested
  logic        po_start_reg;           // First cycle after power-on reset
  pmc_cnt_if   cnt_bus ();             // Counter link

  // Address match helper
  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  wire wr_pwr = sfr_wr_i && hit(sfr_addr_i, PMC_PWR_CTRL_ADDR);
  wire wr_ckp = sfr_wr_i && hit(sfr_addr_i, PMC_CLK_PWR_ADDR);
  wire wake_ev = pin_wake_i || rtc_wake_i;  // Only these wake power-down [R10] [R12]

  // ****************************************
  // Start-up counter
  // ****************************************
  pmc_cycle_cnt u_cnt (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .cnt       (cnt_bus.cnt)
  );

  // Counter loads on phase changes
  always_comb begin
    cnt_bus.load  = 1'b0;
    cnt_bus.value = 18'h0_0000;
    if (wdog_reset_i) begin
      cnt_bus.load  = 1'b1;
      // Crystal wait only after a deep code or from the crystal wait state [R16]
      cnt_bus.value = (pd_active_reg[PMC_PD_DEEP_BIT] || state_reg == PMC_ST_XO_WAIT)
                    ? 18'(XO_START_CYC) : 18'h0_0000;
    end else if (po_start_reg) begin
      cnt_bus.load  = 1'b1;
      cnt_bus.value = 18'(XO_START_CYC); // Power-on crystal wait [R16]
    end else if (state_reg == PMC_ST_XO_WAIT && cnt_bus.done) begin
      cnt_bus.load  = 1'b1;
      cnt_bus.value = 18'(INIT_CYC); // [R16]
    end
  end

  // Power-on marker, high for the first cycle after reset release only.
  // The crystal wait is loaded from here, so the counter's reset branch
  // stays a plain constant and needs no parameter of its own.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      po_start_reg <= 1'b1;
    end else begin
      po_start_reg <= 1'b0;           // One load only
    end
  end

  // ****************************************
  // Mode state machine
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= PMC_ST_XO_WAIT;
    end else if (wdog_reset_i) begin
      state_reg <= PMC_ST_XO_WAIT;    // Any mode ends, restart through init; crystal wait only after a deep code or from the crystal wait state [R4]
    end else begin
      case (state_reg)
        PMC_ST_XO_WAIT: begin
          if (cnt_bus.done && !po_start_reg) state_reg <= PMC_ST_INIT; // [R16]
        end
        PMC_ST_INIT: begin
          if (cnt_bus.done) state_reg <= PMC_ST_RUN; // [R16]
        end
        PMC_ST_RUN: begin
          if (instr_done_i && pd_pend_reg) state_reg <= PMC_ST_PDOWN; // [R7]
          else if (instr_done_i && stop_pend_reg) state_reg <= PMC_ST_STOP; // [R5]
          else if (instr_done_i && idle_pend_reg) state_reg <= PMC_ST_IDLE; // [R1]
        end
        PMC_ST_IDLE: begin
          if (irq_pending_i) state_reg <= PMC_ST_RUN; // [R3]
        end
        PMC_ST_STOP: begin
          state_reg <= PMC_ST_STOP;   // Only watchdog leaves [R5]
        end
        PMC_ST_PDOWN: begin
          if (wake_ev) state_reg <= PMC_ST_WAKE; // [R10]
        end
        PMC_ST_WAKE: begin
          // Slow start from low power osc may lose the irq [R15]
          if (wake_ready_i) state_reg <= PMC_ST_RUN; // [R11]
        end
        default: state_reg <= PMC_ST_XO_WAIT;
      endcase
    end
  end

  // ****************************************
  // Power control register
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      power_control_reg <= PMC_PWR_CTRL_RST;
    end else if (wdog_reset_i) begin
      power_control_reg <= PMC_PWR_CTRL_RST;  // [R4]
    end else begin
      if (wr_pwr) begin
        power_control_reg <= sfr_wdata_i & PMC_PWR_WMASK; // [R17] [R19]
      end
      if (state_reg == PMC_ST_IDLE && irq_pending_i) begin
        power_control_reg[PMC_IDLE_BIT] <= 1'b0; // Hardware clears idle [R3]
      end
    end
  end

  // Pending entry requests wait for instruction completion
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      idle_pend_reg <= 1'b0;
      stop_pend_reg <= 1'b0;
      pd_pend_reg   <= 1'b0;
    end else if (wdog_reset_i || instr_done_i) begin
      // Completion consumes the request; the core completes after the write
      idle_pend_reg <= 1'b0;
      stop_pend_reg <= 1'b0;
      pd_pend_reg   <= 1'b0;
    end else if (state_reg == PMC_ST_RUN) begin
      if (wr_pwr && sfr_wdata_i[PMC_IDLE_BIT]) idle_pend_reg <= 1'b1; // [R1]
      if (wr_pwr && sfr_wdata_i[PMC_STOP_BIT]) stop_pend_reg <= 1'b1; // [R5]
      if (wr_ckp && sfr_wdata_i[2:0] != PMC_PD_NORMAL) pd_pend_reg <= 1'b1; // [R7]
    end
  end

  // ****************************************
  // Clock/power control register
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      clock_power_ctrl_reg <= PMC_CLK_PWR_RST;
    end else if (wdog_reset_i) begin
      clock_power_ctrl_reg <= PMC_CLK_PWR_RST;
    end else if (state_reg == PMC_ST_PDOWN && wake_ev) begin
      clock_power_ctrl_reg <= PMC_PD_NORMAL;     // Hardware clears code [R11]
    end else if (wr_ckp) begin
      clock_power_ctrl_reg <= sfr_wdata_i[2:0];  // Software waits for busy clear [R14]
    end
  end

  // Code in force while powered down, remembered for watchdog start-up
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pd_active_reg    <= PMC_PD_NORMAL;
    end else if (wdog_reset_i) begin
      pd_active_reg    <= PMC_PD_NORMAL;
    end else if (state_reg == PMC_ST_RUN && instr_done_i && pd_pend_reg) begin
      pd_active_reg    <= clock_power_ctrl_reg; // [R8]
    end else if (state_reg == PMC_ST_WAKE && wake_ready_i) begin
      pd_active_reg    <= PMC_PD_NORMAL;
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (sfr_rd_i) begin
      if (hit(sfr_addr_i, PMC_PWR_CTRL_ADDR)) begin
        sfr_rdata_o <= power_control_reg & PMC_PWR_WMASK; // [R17] [R19]
      end else if (hit(sfr_addr_i, PMC_CLK_PWR_ADDR)) begin
        sfr_rdata_o <= {7'h00, slow_clock_level_i}; // Upper bits undefined, read zero [R13]
      end else begin
        sfr_rdata_o <= 8'h00;
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // In idle the CPU clock is not gated, only processing halts [R2]
  assign cpu_hold_o   = (state_reg == PMC_ST_IDLE) || (state_reg == PMC_ST_STOP)
                     || (state_reg == PMC_ST_PDOWN) || (state_reg == PMC_ST_WAKE); // [R2] [R8]
  assign cpu_reset_o  = (state_reg == PMC_ST_XO_WAIT) || (state_reg == PMC_ST_INIT); // [R4]
  assign baud_double_bit_o   = power_control_reg[PMC_BAUD_BIT]; // [R18]
  assign pd_request_o        = (state_reg == PMC_ST_PDOWN); // [R8]
  assign pd_level_o          = pd_active_reg;
  // Deep codes stop the crystal; standby and deep use low power osc [R9]
  // Crystal restarts as soon as power-down ends, wake or watchdog alike
  assign crystal_clock_on_o           = !((state_reg == PMC_ST_PDOWN) && pd_active_reg[PMC_PD_DEEP_BIT]);
  assign slow_clock_source_o = (state_reg == PMC_ST_PDOWN)
                            && (pd_active_reg[PMC_PD_DEEP_BIT] || pd_active_reg == PMC_PD_STBY);

  // ****************************************
  // Checks
  // ****************************************
  sequence idle_sleep_s;
    state_reg == PMC_ST_IDLE && irq_pending_i;
  endsequence
  idle_exit_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [R3]
    idle_sleep_s and !wdog_reset_i |=> state_reg == PMC_ST_RUN && !power_control_reg[0])
    else $error("idle not left on interrupt");
  stop_hold_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [R5]
    state_reg == PMC_ST_STOP && !wdog_reset_i |=> state_reg == PMC_ST_STOP)
    else $error("stop left without watchdog");
  wdog_restart_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [R4]
    wdog_reset_i |=> cpu_reset_o && power_control_reg == 8'h00)
    else $error("watchdog did not restart");
  pd_wake_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [R10]
    state_reg == PMC_ST_PDOWN && !wake_ev && !wdog_reset_i |=> state_reg == PMC_ST_PDOWN)
    else $error("power-down left without wake source");
  pd_clear_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [R11]
    state_reg == PMC_ST_PDOWN && wake_ev && !wdog_reset_i |=> clock_power_ctrl_reg == 3'h0)
    else $error("code not cleared on wake");
  idle_entry_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [R1]
    state_reg == PMC_ST_RUN && !instr_done_i && !wdog_reset_i |=> state_reg != PMC_ST_IDLE)
    else $error("idle before instruction end");
  rsvd_zero_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [R19]
    $past(sfr_rd_i) && $past(sfr_addr_i) == 8'h87 |-> sfr_rdata_o[6:4] == 3'h0)
    else $error("reserved bits not zero");
  baud_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [R18]
    baud_double_bit_o == power_control_reg[7])
    else $error("baud doubler mismatch");
  init_len_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [R16]
    state_reg == PMC_ST_XO_WAIT ##1 state_reg == PMC_ST_INIT |-> cpu_reset_o [*5])
    else $error("init phase too short");
  sequence start_done_s;
    state_reg == PMC_ST_INIT && cnt_bus.done;
  endsequence
  start_run_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [R16]
    start_done_s and !wdog_reset_i |=> state_reg == PMC_ST_RUN && !cpu_reset_o)
    else $error("start-up did not end");
  xo_restart_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [R16]
    wdog_reset_i && pd_request_o && pd_level_o[PMC_PD_DEEP_BIT] |=> !cnt_bus.done)
    else $error("crystal wait skipped after deep power-down");
  pd_entry_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [R7]
    state_reg == PMC_ST_RUN && instr_done_i && pd_pend_reg && !wdog_reset_i
    |=> pd_request_o && cpu_hold_o)
    else $error("power-down not entered at completion");
  stop_entry_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [R5]
    state_reg == PMC_ST_RUN && instr_done_i && stop_pend_reg && !pd_pend_reg && !wdog_reset_i
    |=> state_reg == PMC_ST_STOP && cpu_hold_o)
    else $error("stop not entered at completion");
  idle_hold_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [R2]
    state_reg == PMC_ST_IDLE |-> cpu_hold_o && !cpu_reset_o && !pd_request_o)
    else $error("idle does not only suspend processing");
  deep_crystal_clock_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [R9]
    pd_request_o && pd_level_o[PMC_PD_DEEP_BIT] |-> !crystal_clock_on_o && slow_clock_source_o)
    else $error("deep code left crystal running");
  light_crystal_clock_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [R9]
    pd_request_o && !pd_level_o[PMC_PD_DEEP_BIT] |-> crystal_clock_on_o)
    else $error("crystal stopped by light code");
  wake_run_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [R11]
    state_reg == PMC_ST_WAKE && wake_ready_i && !wdog_reset_i
    |=> !cpu_hold_o && pd_level_o == PMC_PD_NORMAL)
    else $error("wake did not resume processing");
endmodule
`default_nettype wire

//--- testbench/pmc_cpu_model.sv
// CPU core model: register accesses and instruction completions
`default_nettype none
module pmc_cpu_model (
  input  wire logic       sys_clk_i,    // System clock
  output logic            sfr_wr_o,     // Write strobe
  output logic            sfr_rd_o,     // Read strobe
  output logic      [7:0] sfr_addr_o,   // Register address
  output logic      [7:0] sfr_wdata_o,  // Write data
  input  wire logic [7:0] sfr_rdata_i,  // Read data
  output logic            instr_done_o  // Instruction completes
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial begin
    sfr_wr_o = 1'b0;
    sfr_rd_o = 1'b0;
    sfr_addr_o = 8'h00;
    sfr_wdata_o = 8'h00;
    instr_done_o = 1'b0;
  end
  // One-cycle write; the instruction is not complete until step is called
  // Writes come only while the indirect timer interface is idle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    sfr_wr_o = 1'b1;
    sfr_addr_o = a;
    sfr_wdata_o = d;
    @(negedge sys_clk_i);
    sfr_wr_o = 1'b0;
    sfr_wdata_o = ~d;  // Stale data is not left on the bus
  endtask
  // One-cycle read; data is registered, so taken one edge later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk_i);
    sfr_rd_o = 1'b1;
    sfr_addr_o = a;
    @(negedge sys_clk_i);
    sfr_rd_o = 1'b0;
    d = sfr_rdata_i;
  endtask
  // Completion of the current instruction
  task automatic step();
    @(negedge sys_clk_i);
    instr_done_o = 1'b1;
    @(negedge sys_clk_i);
    instr_done_o = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- testbench/tb_power_mode_controller.sv
// Self-checking testbench of the power mode controller
`default_nettype none
module tb_power_mode_controller
  import pmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Signals and instances
  // ****************************************
  localparam int XO = 10;  // Shortened crystal wait
  localparam int IN = 5;   // Shortened init count
  logic sys_clk_i = 1'b0, reset_n_i = 1'b0, wdog = 1'b0, irq = 1'b0, pin = 1'b0;
  logic rtc = 1'b0, slow = 1'b0, wrdy = 1'b0;
  logic wr, rd, done, hold, crst, baud, crystal_clock, src, pdr;
  logic [7:0] addr, wdata, rdata;
  logic [2:0] lvl;
  int miscompares = 0, total_checks = 0;
  always #12.5 sys_clk_i = ~sys_clk_i;  // 40 MHz
  pmc_power_mode_ctrl #(.XO_START_CYC(XO), .INIT_CYC(IN)) i_pmc_power_mode_ctrl (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .wdog_reset_i(wdog), .sfr_wr_i(wr),
    .sfr_rd_i(rd), .sfr_addr_i(addr), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata),
    .instr_done_i(done), .irq_pending_i(irq), .pin_wake_i(pin), .rtc_wake_i(rtc),
    .slow_clock_level_i(slow), .wake_ready_i(wrdy), .cpu_hold_o(hold), .cpu_reset_o(crst),
    .baud_double_bit_o(baud), .crystal_clock_on_o(crystal_clock), .slow_clock_source_o(src),
    .pd_request_o(pdr), .pd_level_o(lvl));
  pmc_cpu_model i_pmc_cpu_model (
    .sys_clk_i(sys_clk_i), .sfr_wr_o(wr), .sfr_rd_o(rd), .sfr_addr_o(addr),
    .sfr_wdata_o(wdata), .sfr_rdata_i(rdata), .instr_done_o(done));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Pulse one of the event inputs for a single cycle
  task automatic pulse(input int which);
    @(negedge sys_clk_i);
    {wdog, irq, pin, rtc} = 4'h8 >> which;
    @(negedge sys_clk_i);
    {wdog, irq, pin, rtc} = 4'h0;
  endtask
  // Bounded count of cycles spent in start-up; lo and hi bound the count
  task automatic start_len(input int lo, input int hi);
    int n;
    n = 0;
    while (crst !== 1'b0 && n < 200) begin
      @(negedge sys_clk_i);
      n++;
    end
    check({7'h0, n >= lo && n <= hi}, 8'h01);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    logic [7:0] d;
    check({7'h0, crst}, 8'h01);
    start_len(XO + IN - 1, XO + IN + 4);
    i_pmc_cpu_model.rd(PMC_PWR_CTRL_ADDR, d);
    check(d, PMC_PWR_CTRL_RST);
    slow = 1'b1;
    i_pmc_cpu_model.rd(PMC_CLK_PWR_ADDR, d);
    check(d, 8'h01);
    slow = 1'b0;
    i_pmc_cpu_model.rd(PMC_CLK_PWR_ADDR, d);
    check(d, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_bits();
    logic [7:0] d;
    i_pmc_cpu_model.wr(PMC_PWR_CTRL_ADDR, 8'hFC);
    i_pmc_cpu_model.rd(PMC_PWR_CTRL_ADDR, d);
    check(d, 8'h8C);
    check({7'h0, baud}, 8'h01);
    check({7'h0, hold}, 8'h00);
    i_pmc_cpu_model.wr(PMC_PWR_CTRL_ADDR, 8'h00);
    check({7'h0, baud}, 8'h00);
    $display("bits test done");
  endtask
  task automatic t_idle();
    logic [7:0] d;
    i_pmc_cpu_model.wr(PMC_PWR_CTRL_ADDR, 8'h05);
    check({7'h0, hold}, 8'h00);
    i_pmc_cpu_model.step();
    check({6'h0, hold, crst}, 8'h02);
    i_pmc_cpu_model.rd(PMC_PWR_CTRL_ADDR, d);
    check(d, 8'h05);
    pulse(1);
    check({7'h0, hold}, 8'h00);
    i_pmc_cpu_model.rd(PMC_PWR_CTRL_ADDR, d);
    check(d, 8'h04);
    $display("idle test done");
  endtask
  task automatic t_pdown();
    logic [2:0] c;
    for (int k = 1; k < 8; k++) begin
      c = 3'(k);
      i_pmc_cpu_model.wr(PMC_CLK_PWR_ADDR, {5'h00, c});
      check({7'h0, pdr}, 8'h00);
      i_pmc_cpu_model.step();
      check({6'h0, pdr, hold}, 8'h03);
      check({5'h00, lvl}, {5'h00, c});
      check({6'h0, crystal_clock, src}, {6'h0, !c[2], c == 3'h3 || c[2]});
      pulse(1);
      check({6'h0, pdr, hold}, 8'h03);
      pulse(c[0] ? 2 : 3);
      check({6'h0, pdr, hold}, 8'h01);
      // Low-power osc codes restore slowly; the wait must still hold
      repeat ((c == 3'h3 || c[2]) ? 20 : 2) @(negedge sys_clk_i);
      check({7'h0, hold}, 8'h01);
      wrdy = 1'b1;
      @(negedge sys_clk_i);
      wrdy = 1'b0;
      check({7'h0, hold}, 8'h00);
      check({5'h00, lvl}, 8'h00);
      i_pmc_cpu_model.step();
      check({7'h0, hold}, 8'h00);
    end
    $display("power-down test done");
  endtask
  // Stop is used once only: nothing but a watchdog ends it
  task automatic t_stop();
    logic [7:0] d;
    i_pmc_cpu_model.wr(PMC_PWR_CTRL_ADDR, 8'h82);
    i_pmc_cpu_model.step();
    check({7'h0, hold}, 8'h01);
    for (int k = 1; k < 4; k++) pulse(k);
    check({7'h0, hold}, 8'h01);
    pulse(0);
    check({7'h0, crst}, 8'h01);
    start_len(IN - 1, IN + 4);
    i_pmc_cpu_model.rd(PMC_PWR_CTRL_ADDR, d);
    check(d, 8'h00);
    $display("stop test done");
  endtask
  task automatic t_deep();
    i_pmc_cpu_model.wr(PMC_CLK_PWR_ADDR, 8'h04);
    i_pmc_cpu_model.step();
    pulse(0);
    check({7'h0, crst}, 8'h01);
    start_len(XO + IN - 1, XO + IN + 4);
    check({6'h0, pdr, crystal_clock}, 8'h01);
    $display("deep watchdog test done");
  endtask
  // Main sequence: reset for three cycles, then every scenario
  initial begin
    repeat (3) @(negedge sys_clk_i);
    reset_n_i = 1'b1;
    t_reset();
    t_bits();
    t_idle();
    t_pdown();
    t_stop();
    t_deep();
    report_and_stop();
  end
  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #(25 * 5000);
    miscompares++;
    report_and_stop();
  end
endmodule
`default_nettype wire
